/* File: rtl/svt_hold_timer.sv */
/*
  Assert-and-hold timer: output is high while the hold condition stands and
  for len_in cycles after it clears. Assumes hold_in is synchronous to clk.
*/
`timescale 1ns/1ns
module svt_hold_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic hold_in,
  input wire logic [svt_pkg::CW-1:0] len_in,
  // Result
  output logic active_out
);
  import svt_pkg::*;

  logic [CW-1:0] remain;

  // Reload while held, then count the release delay down
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      remain <= '0;
      active_out <= 1'b0;
    end else if (hold_in) begin
      remain <= len_in;
      active_out <= 1'b1;
    end else if (remain > CW'(1)) begin
      remain <= remain - CW'(1);
    end else begin
      remain <= '0;
      active_out <= 1'b0;
    end
  end

endmodule

/* File: rtl/svt_top.sv */
/*
  Supervisor timeout and power-good gating: strap-selected watchdog and
  reset timeouts, watchdog disable, forced power-good assertion with timed
  release, APB registers and one level interrupt.
  Assumes comparator results and straps arrive as asynchronous logic levels;
  open-drain pads resolve their wire level from the enables.
*/
`timescale 1ns/1ns
// What this block does
// - Enable input high forces every power-good output asserted low.
// - After enable falls, each power-good output holds its timeout, then releases.
// - Undriven enable input reads as low, so outputs follow supply comparators.
// - Watchdog strap at supply uses default periods; capacitor gives 4.348E6 times C short, 64 times that long.
// - Watchdog strap at ground disables watchdog; fault output never asserts.
// - Reset strap at supply uses default timeout; capacitor gives 4.348E6 times C.
// - Power-good release delay is the preset 6.25 ms.
// - After reset the watchdog allows a long period, then short after first kick.
module svt_top #(
  parameter logic [svt_pkg::CW-1:0] PG_HOLD_CYC_P = svt_pkg::PG_HOLD_CYC,
  parameter logic [svt_pkg::CW-1:0] WD_SHORT_CYC_P = svt_pkg::WD_SHORT_CYC,
  parameter logic [svt_pkg::CW-1:0] WD_LONG_CYC_P = svt_pkg::WD_LONG_CYC,
  parameter logic [svt_pkg::CW-1:0] RST_DEF_CYC_P = svt_pkg::RST_DEF_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [svt_pkg::AW-1:0] paddr_in,
  input wire logic [svt_pkg::DW-1:0] pwdata_in,
  output logic [svt_pkg::DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Pins and straps
  input wire logic pg_enable_in,
  input wire logic pg_enable_driven_in,
  input wire logic [svt_pkg::NPG-1:0] supply_low_in,
  input wire logic [svt_pkg::NTH-1:0] threshold_select_in,
  input wire logic [1:0] watchdog_time_strap_in,
  input wire logic [1:0] reset_time_strap_in,
  input wire logic watchdog_kick_in,
  // Open-drain outputs
  input wire logic [svt_pkg::NPG-1:0] power_good_in,
  output logic [svt_pkg::NPG-1:0] power_good_out,
  output logic [svt_pkg::NPG-1:0] power_good_oe_out,
  output logic reset_out,
  output logic reset_oe_out,
  output logic watchdog_fault_out,
  output logic watchdog_fault_oe_out,
  // Interrupt
  output logic irq_out
);
  import svt_pkg::*;

  localparam int SW = 3 + NPG + NTH + 4 + NPG;

  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic force_eff;
  logic enable_s;
  logic enable_driven_s;
  logic kick_s;
  logic kick_prev;
  logic kick_edge;
  logic [NPG-1:0] low_s;
  logic [NTH-1:0] th_s;
  logic [1:0] wd_strap_s;
  logic [1:0] rst_strap_s;
  logic [NPG-1:0] pg_pin_s;
  logic [NPG-1:0] pg_act;
  logic rst_act;
  logic rst_prev;
  logic [NPG-1:0] pg_prev;
  logic [CW-1:0] rst_len;
  logic [CAPW-1:0] wd_cap;
  logic [CAPW-1:0] rst_cap;
  svt_wd_e wd_state;
  logic [CW-1:0] wd_cnt;
  logic [CW-1:0] wd_limit;
  logic wd_fault;
  logic wd_off;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_evt;
  logic apb_done;
  logic apb_wr;
  logic apb_rd;
  logic [DW-1:0] next_rdata;
  logic next_err;

  // Two-stage synchroniser for every pad input
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {pg_enable_in, pg_enable_driven_in, watchdog_kick_in, supply_low_in,
                   threshold_select_in, watchdog_time_strap_in, reset_time_strap_in,
                   power_good_in};
      pin_sync <= pin_meta;
    end
  end

  // Threshold selects are static straps, so a plain sync suffices
  assign {enable_s, enable_driven_s, kick_s, low_s, th_s, wd_strap_s, rst_strap_s,
          pg_pin_s} = pin_sync;

  // A floating enable behaves as the pulled-down level
  assign force_eff = enable_s & enable_driven_s;

  // Power-good channels: forced by enable or own comparator, timed release
  for (genvar i = 0; i < NPG; i++) begin : g_pg
    svt_hold_timer u_hold (
      .clk_in(mclk_in),
      .rst_in(sys_rst_in),
      .hold_in(force_eff | low_s[i]),
      .len_in(PG_HOLD_CYC_P),
      .active_out(power_good_oe_out[i])
    );
  end
  assign pg_act = power_good_oe_out;

  // Reset timeout source picked by the reset strap
  always_comb begin
    if (rst_strap_s == STRAP_CAP) begin
      rst_len = svt_cap_cycles(rst_cap);
    end else begin
      rst_len = RST_DEF_CYC_P;
    end
  end

  // Reset output held for the selected timeout after all supplies recover
  svt_hold_timer u_rst_hold (
    .clk_in(mclk_in),
    .rst_in(sys_rst_in),
    .hold_in(|low_s),
    .len_in(rst_len),
    .active_out(reset_oe_out)
  );
  assign rst_act = reset_oe_out;

  // Open-drain data lines only ever pull low
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      power_good_out <= '0;
      reset_out <= 1'b0;
      watchdog_fault_out <= 1'b0;
    end else begin
      power_good_out <= '0;
      reset_out <= 1'b0;
      watchdog_fault_out <= 1'b0;
    end
  end

  // Kick edge detect on the synchronised level only
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      kick_prev <= 1'b0;
    end else begin
      kick_prev <= kick_s;
    end
  end
  assign kick_edge = kick_s ^ kick_prev;

  // Watchdog period: long after reset, short after first kick
  assign wd_off = (wd_strap_s == STRAP_GND);
  always_comb begin
    if (wd_strap_s == STRAP_CAP) begin
      if (wd_state == SVT_WD_LONG) begin
        wd_limit = svt_cap_cycles(wd_cap) << LONG_SHIFT;
      end else begin
        wd_limit = svt_cap_cycles(wd_cap);
      end
    end else if (wd_state == SVT_WD_LONG) begin
      wd_limit = WD_LONG_CYC_P;
    end else begin
      wd_limit = WD_SHORT_CYC_P;
    end
  end

  // Watchdog timer; reset activity restarts it, a ground strap parks it
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wd_state <= SVT_WD_LONG;
      wd_cnt <= '0;
      wd_fault <= 1'b0;
    end else if (wd_off) begin
      wd_state <= SVT_WD_OFF;
      wd_cnt <= '0;
      wd_fault <= 1'b0;
    end else if (rst_act || wd_state == SVT_WD_OFF) begin
      wd_state <= SVT_WD_LONG;
      wd_cnt <= '0;
      wd_fault <= 1'b0;
    end else if (kick_edge) begin
      wd_state <= SVT_WD_SHORT;
      wd_cnt <= '0;
      wd_fault <= 1'b0;
    end else if (!wd_fault) begin
      case (wd_state)
        SVT_WD_LONG, SVT_WD_SHORT: begin
          if (wd_cnt + CW'(1) >= wd_limit) begin
            wd_fault <= 1'b1;
          end else begin
            wd_cnt <= wd_cnt + CW'(1);
          end
        end
        default: begin
          wd_cnt <= '0;
        end
      endcase
    end
  end
  assign watchdog_fault_oe_out = wd_fault;

  // Edge history for interrupt events
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_prev <= 1'b0;
      pg_prev <= '0;
    end else begin
      rst_prev <= rst_act;
      pg_prev <= pg_act;
    end
  end
  assign irq_evt[IRQ_WDF] = wd_fault & ~wd_off;
  assign irq_evt[IRQ_RST] = rst_act & ~rst_prev;
  assign irq_evt[IRQ_PGREL] = |(pg_prev & ~pg_act);

  // APB: one wait state, completion on the edge that sees pready high
  assign apb_done = psel_in & penable_in & pready_out;
  assign apb_wr = apb_done & pwrite_in;
  assign apb_rd = apb_done & ~pwrite_in;

  // Read data and error for the addressed word
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    case (paddr_in)
      OFS_STATUS: begin
        next_rdata[ST_PG_LSB +: NPG] = pg_act;
        next_rdata[ST_RST_BIT] = rst_act;
        next_rdata[ST_WDF_BIT] = wd_fault;
        next_rdata[ST_FORCE_BIT] = force_eff;
        next_rdata[ST_TH_LSB +: NTH] = th_s;
        next_rdata[ST_PIN_LSB +: NPG] = pg_pin_s;
      end
      OFS_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
      OFS_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      OFS_WD_CAP: next_rdata[CAPW-1:0] = wd_cap;
      OFS_RST_CAP: next_rdata[CAPW-1:0] = rst_cap;
      default: next_err = 1'b1;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end else if (psel_in && penable_in && !pready_out) begin
      pready_out <= 1'b1;
      prdata_out <= pwrite_in ? '0 : next_rdata;
      pslverr_out <= next_err;
    end else begin
      pready_out <= 1'b0;
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end
  end

  // Writable configuration; capacitor words steer the timeouts
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_mask <= IRQ_MASK_RST;
      wd_cap <= CAP_RST;
      rst_cap <= CAP_RST;
    end else if (apb_wr) begin
      case (paddr_in)
        OFS_IRQ_MASK: irq_mask <= pwdata_in[IRQ_W-1:0];
        OFS_WD_CAP: wd_cap <= pwdata_in[CAPW-1:0];
        OFS_RST_CAP: rst_cap <= pwdata_in[CAPW-1:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // Sticky events, cleared by reading; only the reported bits clear, so an
  // event in the wait cycle or in the read cycle itself is not lost
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_stat <= '0;
    end else if (apb_rd && paddr_in == OFS_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~prdata_out[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat & irq_mask);
    end
  end

  // Helper: cycles channel 0 has stayed asserted since its last hold
  logic [CW-1:0] rel_cnt;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rel_cnt <= '0;
    end else if (force_eff || low_s[0]) begin
      rel_cnt <= '0;
    end else if (pg_act[0]) begin
      rel_cnt <= rel_cnt + CW'(1);
    end
  end

  // Checks
  sequence force_drop_s;
    $fell(force_eff) && !(|low_s);
  endsequence
  sequence all_held_s;
    (&pg_act) [*8];
  endsequence

  force_pg_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    force_eff |=> &pg_act)
    else $error("Power-good not forced by enable");
  release_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    force_drop_s |-> all_held_s)
    else $error("Power-good released before its timeout");
  pull_down_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!enable_driven_s && !(|low_s) && !pg_act[0]) |=> !pg_act[0])
    else $error("Undriven enable treated as high");
  wd_period_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (wd_strap_s == STRAP_VCC && wd_state == SVT_WD_SHORT) |-> wd_limit == WD_SHORT_CYC_P)
    else $error("Default watchdog period not used");
  wd_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (wd_strap_s == STRAP_GND) [*2] |-> !watchdog_fault_oe_out)
    else $error("Disabled watchdog raised a fault");
  rst_len_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (rst_strap_s == STRAP_CAP) |-> rst_len == svt_cap_cycles(rst_cap))
    else $error("Reset timeout ignores capacitor value");
  pg_delay_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $fell(pg_act[0]) |-> rel_cnt == PG_HOLD_CYC_P)
    else $error("Power-good release delay wrong");
  wd_long_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (rst_act && !wd_off) |=> (wd_state == SVT_WD_LONG && wd_cnt == '0))
    else $error("Watchdog not restarted in long period");
  wd_short_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (kick_edge && !rst_act && !wd_off && wd_state != SVT_WD_OFF)
      |=> wd_state == SVT_WD_SHORT)
    else $error("Kick did not select short period");

endmodule

/* File: shared/svt_pkg.sv */
/*
  Shared constants of the supervisor timeout and power-good gating block:
  APB register offsets, field positions, strap encodings and timing figures.
  Assumes a 125 MHz system clock; every time is kept in ns and turned into
  cycles here.
*/
package svt_pkg;

  // Clock period and register geometry
  localparam int unsigned CLK_NS = 8;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CW = 40;
  localparam int NPG = 8;
  localparam int NTH = 5;
  localparam int CAPW = 16;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [AW-1:0] OFS_WD_CAP = 8'h0c;
  localparam logic [AW-1:0] OFS_RST_CAP = 8'h10;

  // Status word fields
  localparam int ST_PG_LSB = 0;
  localparam int ST_RST_BIT = 8;
  localparam int ST_WDF_BIT = 9;
  localparam int ST_FORCE_BIT = 10;
  localparam int ST_TH_LSB = 16;
  localparam int ST_PIN_LSB = 24;

  // Interrupt status / mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_WDF = 0;
  localparam int IRQ_RST = 1;
  localparam int IRQ_PGREL = 2;

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [CAPW-1:0] CAP_RST = 16'h0000;

  // Strap level encodings as decoded by the pad comparators
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VCC = 2'h1;
  localparam logic [1:0] STRAP_CAP = 2'h2;

  // Times in ns, cycle counts derived from them
  localparam longint unsigned PG_HOLD_NS = 64'd6_250_000;
  localparam longint unsigned WD_SHORT_NS = 64'd1_440_000_000;
  localparam longint unsigned WD_LONG_NS = 64'd92_160_000_000;
  localparam longint unsigned RST_DEF_NS = 64'd200_000_000;
  localparam logic [CW-1:0] PG_HOLD_CYC = CW'(PG_HOLD_NS / CLK_NS);
  localparam logic [CW-1:0] WD_SHORT_CYC = CW'(WD_SHORT_NS / CLK_NS);
  localparam logic [CW-1:0] WD_LONG_CYC = CW'(WD_LONG_NS / CLK_NS);
  localparam logic [CW-1:0] RST_DEF_CYC = CW'(RST_DEF_NS / CLK_NS);

  // 4.348E6 s per farad is 4348 ns per picofarad
  localparam longint unsigned CAP_NS_PER_PF = 64'd4348;
  localparam int LONG_SHIFT = 6;

  // Watchdog phases
  typedef enum logic [1:0] {
    SVT_WD_OFF,
    SVT_WD_LONG,
    SVT_WD_SHORT
  } svt_wd_e;

  // Capacitor value in pF to timeout cycles, rounded down
  function automatic logic [CW-1:0] svt_cap_cycles(input logic [CAPW-1:0] pf);
    svt_cap_cycles = CW'((64'(pf) * CAP_NS_PER_PF) / CLK_NS);
  endfunction

endpackage

/* File: test/supervisor_timeout_config_test.sv */
/*
  Self-checking bench of the supervisor block: APB tasks and timed pin tests.
  Assumes the board model for straps and wires, and shortened timeouts.
*/
`timescale 1ns/1ns
module supervisor_timeout_config_test;
  import svt_pkg::*;
  localparam int PGH = 20;
  localparam int RSTD = 30;
  localparam int CAP1 = 543; // 1 pF is 4348 ns, floored to cycles
  // Design and model nets
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, kick;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rd;
  logic en_cmd, float_cmd, pg_en, pg_drv, rst_oe, wdf_oe, irq, err, rst_dat, wdf_dat;
  logic [1:0] wd_cmd, rst_cmd, wd_strap, rst_strap;
  logic [NPG-1:0] supply_low, pg_oe, pg_wire, pg_dat;
  logic [NTH-1:0] th;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0, t;

  svt_top #(.PG_HOLD_CYC_P(CW'(PGH)), .WD_SHORT_CYC_P(CW'(50)), .WD_LONG_CYC_P(CW'(200)),
    .RST_DEF_CYC_P(CW'(RSTD))) svt_top_i (
    .mclk_in(mclk), .sys_rst_in(sys_rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pg_enable_in(pg_en),
    .pg_enable_driven_in(pg_drv), .supply_low_in(supply_low), .threshold_select_in(th),
    .watchdog_time_strap_in(wd_strap), .reset_time_strap_in(rst_strap),
    .watchdog_kick_in(kick), .power_good_in(pg_wire), .power_good_out(pg_dat),
    .power_good_oe_out(pg_oe), .reset_out(rst_dat), .reset_oe_out(rst_oe),
    .watchdog_fault_out(wdf_dat), .watchdog_fault_oe_out(wdf_oe), .irq_out(irq));

  svt_board_model svt_board_model_i (.en_cmd_in(en_cmd), .float_cmd_in(float_cmd),
    .wd_cmd_in(wd_cmd), .rst_cmd_in(rst_cmd), .power_good_oe_in(pg_oe),
    .pg_enable_out(pg_en), .pg_enable_driven_out(pg_drv), .threshold_select_out(th),
    .watchdog_time_strap_out(wd_strap), .reset_time_strap_out(rst_strap),
    .power_good_wire_out(pg_wire));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Cycle count; the ceiling cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; pready sampled at the rising edge that completes it,
  // with no cycle count assumed: only the bench ceiling ends a hung wait
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  // Settle at the falling edge once the cycle count is reached
  task automatic at(input int c);
    while (cyc < c) @(posedge mclk);
    @(negedge mclk);
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    kick = 1'b0;
    en_cmd = 1'b0;
    float_cmd = 1'b0;
    wd_cmd = STRAP_VCC;
    rst_cmd = STRAP_VCC;
    supply_low = 8'h00;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t0 = cyc;
    // Reset values and an unmapped word
    rdchk("irq_mask", OFS_IRQ_MASK, 32'h0);
    rdchk("wd_cap", OFS_WD_CAP, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    // Open enable pin must not force outputs
    @(posedge mclk);
    en_cmd <= 1'b1;
    float_cmd <= 1'b1;
    at(cyc + 10);
    check("oe floating", 32'(pg_oe), 32'h0);
    @(posedge mclk);
    float_cmd <= 1'b0;
    at(cyc + 6);
    check("oe forced", 32'(pg_oe), 32'hff);
    check("od data low", {22'h0, rst_dat, wdf_dat, pg_dat}, 32'h0);
    rdchk("status forced", OFS_STATUS, 32'h001504ff);
    apb(1'b1, OFS_IRQ_MASK, 32'h4);
    // Release of the enable: hold, then drop with an interrupt
    @(posedge mclk);
    en_cmd <= 1'b0;
    t = cyc;
    at(t + PGH - 4);
    check("oe held", 32'(pg_oe), 32'hff);
    at(t + PGH + 8);
    check("oe released", 32'(pg_oe), 32'h0);
    at(cyc + 2);
    check("irq pg release", 32'(irq), 32'h1);
    rdchk("irq_stat", OFS_IRQ_STAT, 32'h4);
    rdchk("irq_stat cleared", OFS_IRQ_STAT, 32'h0);
    at(cyc + 2);
    check("irq cleared", 32'(irq), 32'h0);
    rdchk("status released", OFS_STATUS, 32'hff150000);
    // Default long period, then default short after a kick
    at(t0 + 185);
    check("wdf long early", 32'(wdf_oe), 32'h0);
    at(t0 + 215);
    check("wdf long", 32'(wdf_oe), 32'h1);
    check("irq masked", 32'(irq), 32'h0);
    rdchk("irq_stat wdf", OFS_IRQ_STAT, 32'h1);
    @(posedge mclk);
    kick <= 1'b1;
    t = cyc;
    at(t + 45);
    check("wdf short early", 32'(wdf_oe), 32'h0);
    at(t + 60);
    check("wdf short", 32'(wdf_oe), 32'h1);
    // Grounded strap switches the watchdog off
    @(posedge mclk);
    wd_cmd <= STRAP_GND;
    at(cyc + 300);
    check("wdf off", 32'(wdf_oe), 32'h0);
    // Default reset timeout after a dip on channel 0
    @(posedge mclk);
    supply_low <= 8'h01;
    at(cyc + 6);
    check("reset default set", 32'(rst_oe), 32'h1);
    rdchk("status reset", OFS_STATUS, 32'hfe150101);
    @(posedge mclk);
    supply_low <= 8'h00;
    t = cyc;
    at(t + RSTD - 2);
    check("reset default held", 32'(rst_oe), 32'h1);
    at(t + RSTD + 6);
    check("reset default done", 32'(rst_oe), 32'h0);
    rdchk("irq_stat events", OFS_IRQ_STAT, 32'h7);
    // Capacitor timeouts of 1 pF on both straps
    apb(1'b1, OFS_WD_CAP, 32'h1);
    apb(1'b1, OFS_RST_CAP, 32'h1);
    rdchk("wd_cap set", OFS_WD_CAP, 32'h1);
    rdchk("rst_cap", OFS_RST_CAP, 32'h1);
    @(posedge mclk);
    wd_cmd <= STRAP_CAP;
    rst_cmd <= STRAP_CAP;
    supply_low <= 8'h08;
    at(cyc + 10);
    check("reset low supply", 32'(rst_oe), 32'h1);
    check("oe low supply", 32'(pg_oe), 32'h08);
    @(posedge mclk);
    supply_low <= 8'h00;
    t = cyc;
    at(t + CAP1 - 13);
    check("reset cap held", 32'(rst_oe), 32'h1);
    at(t + CAP1 + 17);
    check("reset cap done", 32'(rst_oe), 32'h0);
    at(t + 64 * CAP1 - 1200);
    check("wdf cap long early", 32'(wdf_oe), 32'h0);
    at(t + 64 * CAP1 + 700);
    check("wdf cap long", 32'(wdf_oe), 32'h1);
    @(posedge mclk);
    kick <= 1'b0;
    t = cyc;
    at(t + CAP1 - 13);
    check("wdf cap early", 32'(wdf_oe), 32'h0);
    at(t + CAP1 + 17);
    check("wdf cap", 32'(wdf_oe), 32'h1);
    give_verdict();
  end
endmodule

/* File: test/svt_board_model.sv */
/*
  Board model of the supervisor: straps, threshold pins, enable pin driver
  and pull-ups on the open-drain power-good wires.
  Assumes the bench steers it through plain command inputs.
*/
`timescale 1ns/1ns
module svt_board_model #(
  parameter logic [svt_pkg::NTH-1:0] TH_P = 5'h15
) (
  // Commands from the bench
  input wire logic en_cmd_in,
  input wire logic float_cmd_in,
  input wire logic [1:0] wd_cmd_in,
  input wire logic [1:0] rst_cmd_in,
  // Device side
  input wire logic [svt_pkg::NPG-1:0] power_good_oe_in,
  output logic pg_enable_out,
  output logic pg_enable_driven_out,
  output logic [svt_pkg::NTH-1:0] threshold_select_out,
  output logic [1:0] watchdog_time_strap_out,
  output logic [1:0] reset_time_strap_out,
  output logic [svt_pkg::NPG-1:0] power_good_wire_out
);
  import svt_pkg::*;
  // Floating pin sits at the pull-down level, never at its last value
  assign pg_enable_driven_out = !float_cmd_in;
  assign pg_enable_out = float_cmd_in ? 1'b0 : en_cmd_in;
  // Thresholds tied hard to ground or bias, never left open
  assign threshold_select_out = TH_P;
  assign watchdog_time_strap_out = wd_cmd_in;
  assign reset_time_strap_out = rst_cmd_in;
  // Pull-ups win on every released wire
  assign power_good_wire_out = ~power_good_oe_in;
endmodule
